/* File: hw/bwc_edge_detect.sv */
/*
  edge detector on the filtered wake levels, ahead of polarity inversion.
  assumes filtered levels from bwc_glitch_filter; pulses last one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module bwc_edge_detect #(
  parameter int N = 7
) (
  input wire logic core_clk,
  input wire logic rst_b,
  bwc_wake_if.edge_side w
);

  logic [N-1:0] prev_q;
  logic [N-1:0] rise_q;
  logic [N-1:0] fall_q;
  logic [N-1:0] rise_d;
  logic [N-1:0] fall_d;
  logic settle_q;

  // edges count only while the pin's input buffer is on; the load cycle is no edge,
  // nor the one after it: prev_q still holds the reset level while filt shows the pin
  always_comb
  begin
    rise_d = (w.init || settle_q) ? '0 : (w.buf_en & w.filt & ~prev_q); // [RULE10]
    fall_d = (w.init || settle_q) ? '0 : (w.buf_en & ~w.filt & prev_q); // [RULE10]
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_q <= '1;
      settle_q <= 1'b1;
      rise_q <= '0;
      fall_q <= '0;
    end
    else
    begin
      prev_q <= w.filt;
      settle_q <= w.init;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign w.rise = rise_q;
  assign w.fall = fall_q;

endmodule : bwc_edge_detect
`default_nettype wire

/* File: hw/bwc_glitch_filter.sv */
/*
  per-pin glitch filter for the wake inputs.
  assumes raw levels synchronous to core_clk and a one-cycle init pulse after reset.
*/
`timescale 1ns/1ns
`default_nettype none
module bwc_glitch_filter #(
  parameter int N = 7
) (
  input wire logic core_clk,
  input wire logic rst_b,
  bwc_wake_if.filt_side w
);

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      logic filt_q;
      logic filt_d;
      logic [3:0] cnt_q;
      logic [3:0] cnt_d;

      // a new level must stand FILT_CYCLES cycles unless the filter is bypassed or the init pulse loads it
      always_comb
      begin
        filt_d = filt_q;
        cnt_d = 4'h0;
        if (w.init || w.bypass) // [RULE6] [RULE8]
        begin
          filt_d = w.raw[g];
        end
        else if (w.raw[g] != filt_q)
        begin
          if (cnt_q == 4'(bwc_pkg::FILT_CYCLES - 1))
          begin
            filt_d = w.raw[g];
          end
          else
          begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          filt_q <= 1'b1;
          cnt_q <= 4'h0;
        end
        else
        begin
          filt_q <= filt_d;
          cnt_q <= cnt_d;
        end
      end

      assign w.filt[g] = filt_q;
    end
  endgenerate

endmodule : bwc_glitch_filter
`default_nettype wire

/* File: hw/bwc_pkg.sv */
/*
  constants shared by the battery wake control block: register offsets,
  field positions, reset values and the input glitch filter length.
  assumes byte addresses on an 8-bit register port, one 32-bit word per register.
*/
package bwc_pkg;

  localparam int NUM_WAKE = 7;

  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] OFF_LATCH_ENABLE = 8'h04;
  localparam logic [7:0] OFF_LATCH_CLEAR = 8'h08;
  localparam logic [7:0] OFF_INPUT_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_RESERVED_SLOT = 8'h10;
  localparam logic [7:0] OFF_INPUT_POLARITY = 8'h14;
  localparam logic [7:0] OFF_RISING_EDGE = 8'h18;
  localparam logic [7:0] OFF_FALLING_EDGE = 8'h1c;
  localparam logic [7:0] OFF_BUFFER_ENABLE = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

  // control_status field positions
  localparam int BIT_POWER_OUT = 8;
  localparam int BIT_FW_OVERRIDE = 9;
  localparam int BIT_FW_LEVEL = 10;
  localparam int BIT_FILTER_BYPASS = 11;
  localparam int BIT_WEEKLY = 16;
  localparam int BIT_RTC = 17;

  // interrupt status / mask field positions
  localparam int IRQ_RISE = 0;
  localparam int IRQ_FALL = 1;
  localparam int IRQ_RTC = 2;
  localparam int IRQ_WEEKLY = 3;
  localparam int IRQ_POWER = 4;
  localparam int NUM_IRQ = 5;

  // values after reset
  localparam logic [6:0] RST_INPUT_ENABLE = 7'h7f;
  localparam logic [6:0] RST_BUFFER_ENABLE = 7'h00;
  localparam logic [6:0] RST_POLARITY = 7'h00;
  localparam logic [6:0] RST_LATCH_ENABLE = 7'h00;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;

  // cycles a pin must hold a new level before the filter passes it
  localparam int FILT_CYCLES = 4;

endpackage : bwc_pkg

/* File: hw/bwc_wake_ctrl.sv */
/*
  battery wake control: register file, wake status latching, alarm latches,
  edge status, power enable output and one level interrupt.
  assumes a single-cycle register port on core_clk, wake pins and alarms
  synchronous to core_clk, and rst_b as the battery-domain reset.
*/
// What this block does
// RULE1: registers decode at base plus offset 00,04,08,0C,14,18,1C,20 as listed.
// RULE2: with its latch enable set, rtc_alarm_status bit 17 goes to one while the rtc alarm is high.
// RULE3: writing rtc_alarm_latch_clear clears the latched rtc_alarm_status.
// RULE4: with its latch enable set, weekly_alarm_status bit 16 goes to one while the weekly alarm is high.
// RULE5: writing weekly_alarm_latch_clear clears the latched weekly_alarm_status.
// RULE6: after reset the wake status bits 6:0 take the present pin levels, not a constant.
// RULE7: the power_enable_output status bit shows the combined output, not a fixed value.
// RULE8: glitch_filter_bypass at one turns off every wake input filter; it resets to zero.
// RULE9: with firmware_output_override at one the output follows firmware_output_level; this block honours it only while main_power_good is high.
// RULE10: polarity inversion sits after filtering and before latching; edges are found before it.
// RULE11: reserved bits and offset 0x10 read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module bwc_wake_ctrl #(
  parameter int N = bwc_pkg::NUM_WAKE
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [N-1:0] wake_input_n,
  input wire logic rtc_alarm,
  input wire logic weekly_alarm,
  input wire logic main_power_good,
  output logic power_enable_output,
  output logic irq
);

  bwc_wake_if #(.N(N)) wif ();

  // control registers
  logic [N-1:0] in_en_q, in_en_d;
  logic [N-1:0] buf_en_q, buf_en_d;
  logic [N-1:0] pol_q, pol_d;
  logic [N-1:0] lat_en_q, lat_en_d;
  logic rtc_le_q, rtc_le_d;
  logic week_le_q, week_le_d;
  logic fw_ovr_q, fw_ovr_d;
  logic fw_lvl_q, fw_lvl_d;
  logic bypass_q, bypass_d;
  logic [bwc_pkg::NUM_IRQ-1:0] irq_mask_q, irq_mask_d;

  // status state
  logic init_q;
  logic [N-1:0] stat_q, stat_d;
  logic [N-1:0] rise_st_q, rise_st_d;
  logic [N-1:0] fall_st_q, fall_st_d;
  logic rtc_st_q, rtc_st_d;
  logic week_st_q, week_st_d;
  logic pwr_q, pwr_d;
  logic [bwc_pkg::NUM_IRQ-1:0] irq_st_q, irq_st_d;
  logic irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;

  // write decode
  logic wr_cs, wr_le, wr_lc, wr_ie, wr_pol, wr_re, wr_fe, wr_be, wr_mask;
  logic rd_irq;
  logic [N-1:0] lvl;
  logic [N-1:0] wake_clr;
  logic rtc_clr, week_clr;
  logic hw_out;
  logic [bwc_pkg::NUM_IRQ-1:0] irq_ev;

  // one compare reused by every decode line
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_cs = reg_wr && hit(reg_addr, bwc_pkg::OFF_CONTROL_STATUS); // [RULE1]
  assign wr_le = reg_wr && hit(reg_addr, bwc_pkg::OFF_LATCH_ENABLE); // [RULE1]
  assign wr_lc = reg_wr && hit(reg_addr, bwc_pkg::OFF_LATCH_CLEAR); // [RULE1]
  assign wr_ie = reg_wr && hit(reg_addr, bwc_pkg::OFF_INPUT_ENABLE); // [RULE1]
  assign wr_pol = reg_wr && hit(reg_addr, bwc_pkg::OFF_INPUT_POLARITY); // [RULE1]
  assign wr_re = reg_wr && hit(reg_addr, bwc_pkg::OFF_RISING_EDGE); // [RULE1]
  assign wr_fe = reg_wr && hit(reg_addr, bwc_pkg::OFF_FALLING_EDGE); // [RULE1]
  assign wr_be = reg_wr && hit(reg_addr, bwc_pkg::OFF_BUFFER_ENABLE); // [RULE1]
  assign wr_mask = reg_wr && hit(reg_addr, bwc_pkg::OFF_IRQ_MASK);
  assign rd_irq = reg_rd && hit(reg_addr, bwc_pkg::OFF_IRQ_STATUS);

  // latch clear register is write-only: each one bit clears its latch
  assign wake_clr = wr_lc ? reg_wdata[N-1:0] : '0;
  assign rtc_clr = wr_lc && reg_wdata[bwc_pkg::BIT_RTC];
  assign week_clr = wr_lc && reg_wdata[bwc_pkg::BIT_WEEKLY];

  // helpers: the buffer is on when the pin feeds the output or is explicitly enabled
  assign wif.raw = wake_input_n;
  assign wif.bypass = bypass_q; // [RULE8]
  assign wif.init = init_q;
  assign wif.buf_en = in_en_q | buf_en_q;

  bwc_glitch_filter #(.N(N)) u_filter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .w(wif.filt_side)
  );

  bwc_edge_detect #(.N(N)) u_edge (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .w(wif.edge_side)
  );

  // inversion after the filter; at default polarity a low level means asserted
  assign lvl = wif.filt ^ pol_q; // [RULE10]

  // hardware combination: any enabled asserted input, or either alarm (live or latched)
  assign hw_out = (|(in_en_q & ~stat_q)) | rtc_alarm | rtc_st_q | weekly_alarm | week_st_q;

  // control register next values; reserved bits are simply not stored
  always_comb
  begin
    in_en_d = wr_ie ? reg_wdata[N-1:0] : in_en_q;
    buf_en_d = wr_be ? reg_wdata[N-1:0] : buf_en_q;
    pol_d = wr_pol ? reg_wdata[N-1:0] : pol_q;
    lat_en_d = wr_le ? reg_wdata[N-1:0] : lat_en_q;
    rtc_le_d = wr_le ? reg_wdata[bwc_pkg::BIT_RTC] : rtc_le_q;
    week_le_d = wr_le ? reg_wdata[bwc_pkg::BIT_WEEKLY] : week_le_q;
    fw_ovr_d = wr_cs ? reg_wdata[bwc_pkg::BIT_FW_OVERRIDE] : fw_ovr_q;
    fw_lvl_d = wr_cs ? reg_wdata[bwc_pkg::BIT_FW_LEVEL] : fw_lvl_q;
    bypass_d = wr_cs ? reg_wdata[bwc_pkg::BIT_FILTER_BYPASS] : bypass_q; // [RULE8]
    irq_mask_d = wr_mask ? reg_wdata[bwc_pkg::NUM_IRQ-1:0] : irq_mask_q;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_en_q <= bwc_pkg::RST_INPUT_ENABLE[N-1:0];
      buf_en_q <= bwc_pkg::RST_BUFFER_ENABLE[N-1:0];
      pol_q <= bwc_pkg::RST_POLARITY[N-1:0];
      lat_en_q <= bwc_pkg::RST_LATCH_ENABLE[N-1:0];
      rtc_le_q <= 1'b0;
      week_le_q <= 1'b0;
      fw_ovr_q <= 1'b0;
      fw_lvl_q <= 1'b0;
      bypass_q <= 1'b0; // [RULE8]
      irq_mask_q <= bwc_pkg::RST_IRQ_MASK;
    end
    else
    begin
      in_en_q <= in_en_d;
      buf_en_q <= buf_en_d;
      pol_q <= pol_d;
      lat_en_q <= lat_en_d;
      rtc_le_q <= rtc_le_d;
      week_le_q <= week_le_d;
      fw_ovr_q <= fw_ovr_d;
      fw_lvl_q <= fw_lvl_d;
      bypass_q <= bypass_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // status next values; a new event beats a clear in the same cycle
  always_comb
  begin
    if (init_q)
    begin
      stat_d = wake_input_n ^ pol_q; // [RULE6]
    end
    else
    begin
      // a latched input holds its asserted (low) state until cleared
      stat_d = (lat_en_q & ~wake_clr) & stat_q & lvl | (~(lat_en_q & ~wake_clr)) & lvl; // [RULE10]
    end
    rise_st_d = wif.rise | (rise_st_q & ~(wr_re ? reg_wdata[N-1:0] : '0));
    fall_st_d = wif.fall | (fall_st_q & ~(wr_fe ? reg_wdata[N-1:0] : '0));
    rtc_st_d = (rtc_le_q && rtc_alarm) || (rtc_st_q && !rtc_clr); // [RULE2] [RULE3]
    week_st_d = (week_le_q && weekly_alarm) || (week_st_q && !week_clr); // [RULE4] [RULE5]
    // firmware only steers the output while main power is good
    if (fw_ovr_q && main_power_good)
    begin
      pwr_d = fw_lvl_q; // [RULE9]
    end
    else
    begin
      pwr_d = hw_out; // [RULE9]
    end
    irq_ev[bwc_pkg::IRQ_RISE] = |wif.rise;
    irq_ev[bwc_pkg::IRQ_FALL] = |wif.fall;
    irq_ev[bwc_pkg::IRQ_RTC] = rtc_st_d && !rtc_st_q;
    irq_ev[bwc_pkg::IRQ_WEEKLY] = week_st_d && !week_st_q;
    irq_ev[bwc_pkg::IRQ_POWER] = pwr_d != pwr_q;
    irq_st_d = irq_ev | (rd_irq ? '0 : irq_st_q);
    irq_d = |(irq_st_d & irq_mask_q);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_q <= 1'b1;
      stat_q <= '1;
      rise_st_q <= '0;
      fall_st_q <= '0;
      rtc_st_q <= 1'b0;
      week_st_q <= 1'b0;
      pwr_q <= 1'b0;
      irq_st_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      init_q <= 1'b0; // pins are loaded at the first edge after release
      stat_q <= stat_d;
      rise_st_q <= rise_st_d;
      fall_st_q <= fall_st_d;
      rtc_st_q <= rtc_st_d;
      week_st_q <= week_st_d;
      pwr_q <= pwr_d;
      irq_st_q <= irq_st_d;
      irq_q <= irq_d;
    end
  end

  // read mux; unmapped, reserved and write-only offsets read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (!reg_rd)
    begin
      rdata_d = 32'h0000_0000;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_CONTROL_STATUS)) // [RULE1]
    begin
      rdata_d[N-1:0] = stat_q; // [RULE6]
      rdata_d[bwc_pkg::BIT_POWER_OUT] = pwr_q; // [RULE7]
      rdata_d[bwc_pkg::BIT_FW_OVERRIDE] = fw_ovr_q;
      rdata_d[bwc_pkg::BIT_FW_LEVEL] = fw_lvl_q;
      rdata_d[bwc_pkg::BIT_FILTER_BYPASS] = bypass_q;
      rdata_d[bwc_pkg::BIT_WEEKLY] = week_st_q; // [RULE4]
      rdata_d[bwc_pkg::BIT_RTC] = rtc_st_q; // [RULE2]
    end
    else if (hit(reg_addr, bwc_pkg::OFF_LATCH_ENABLE))
    begin
      rdata_d[N-1:0] = lat_en_q;
      rdata_d[bwc_pkg::BIT_WEEKLY] = week_le_q;
      rdata_d[bwc_pkg::BIT_RTC] = rtc_le_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_INPUT_ENABLE))
    begin
      rdata_d[N-1:0] = in_en_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_INPUT_POLARITY))
    begin
      rdata_d[N-1:0] = pol_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_RISING_EDGE))
    begin
      rdata_d[N-1:0] = rise_st_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_FALLING_EDGE))
    begin
      rdata_d[N-1:0] = fall_st_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_BUFFER_ENABLE))
    begin
      rdata_d[N-1:0] = buf_en_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_IRQ_STATUS))
    begin
      rdata_d[bwc_pkg::NUM_IRQ-1:0] = irq_st_q;
    end
    else if (hit(reg_addr, bwc_pkg::OFF_IRQ_MASK))
    begin
      rdata_d[bwc_pkg::NUM_IRQ-1:0] = irq_mask_q;
    end
    else
    begin
      rdata_d = 32'h0000_0000; // [RULE11]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign power_enable_output = pwr_q;
  assign irq = irq_q;

endmodule : bwc_wake_ctrl
`default_nettype wire

/* File: hw/bwc_wake_if.sv */
/*
  bundle between the core and its two helpers: raw and filtered wake levels,
  filter bypass, the post-reset load pulse and the edge pulses.
  assumes all three parties share core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface bwc_wake_if #(parameter int N = 7);
  logic [N-1:0] raw;
  logic [N-1:0] filt;
  logic [N-1:0] buf_en;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic bypass;
  logic init;
  modport core (output raw, buf_en, bypass, init, input filt, rise, fall);
  modport filt_side (input raw, bypass, init, output filt);
  modport edge_side (input filt, buf_en, init, output rise, fall);
endinterface : bwc_wake_if
`default_nettype wire

/* File: testbench/bwc_wake_ctrl_chk.sv */
/*
  assertions on the register port and the power enable output.
  assumes it is bound to bwc_wake_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module bwc_wake_ctrl_chk #(
  parameter int N = 7
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rtc_alarm,
  input wire logic main_power_good,
  input wire logic power_enable_output
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // one read request at a given offset
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_rsvd_slot_zero: assert property (s_rd(8'h10) |=> reg_rdata == 32'h0000_0000)
    else $error("reserved offset read not zero");
  a_clear_reads_zero: assert property (s_rd(8'h08) |=> reg_rdata == 32'h0000_0000)
    else $error("write-only clear register read not zero");
  a_rsvd_bits_zero: assert property (s_rd(8'h00) |=> reg_rdata[31:18] == 14'h0000
    && reg_rdata[15:13] == 3'h0)
    else $error("reserved status bits not zero");
  a_edge_hi_zero: assert property ((s_rd(8'h18) or s_rd(8'h1c)) |=> reg_rdata[31:7] == 0)
    else $error("edge status upper bits not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h28 |=> reg_rdata == 0)
    else $error("unmapped offset read not zero");
  // the status bit must be the very output the pin sees
  a_power_bit_match: assert property (s_rd(8'h00) |=> reg_rdata[8] == $past(power_enable_output))
    else $error("power status bit differs from output");
  a_alarm_wakes: assert property ((rtc_alarm && !main_power_good)[*3] |-> power_enable_output)
    else $error("alarm without main power did not raise output");
endmodule : bwc_wake_ctrl_chk
`default_nettype wire

/* File: testbench/bwc_wake_partner.sv */
/*
  far side of the wake block: wake buttons, both alarms, main power good.
  assumes core_clk from the bench; every change lands just after an edge.
*/
`timescale 1ns/1ns
`default_nettype none
module bwc_wake_partner (
  input wire logic core_clk,
  output logic [6:0] wake_input_n,
  output logic rtc_alarm,
  output logic weekly_alarm,
  output logic main_power_good
);
  // buttons released, alarms quiet, main rail up
  initial
  begin
    wake_input_n = 7'h7f;
    rtc_alarm = 1'b0;
    weekly_alarm = 1'b0;
    main_power_good = 1'b1;
  end

  task automatic set_pins(input logic [6:0] v);
    @(posedge core_clk);
    wake_input_n <= v;
  endtask : set_pins

  // short holds model contact bounce that the filter must swallow
  task automatic press(input int k, input int n);
    @(posedge core_clk);
    wake_input_n[k] <= 1'b0;
    repeat (n) @(posedge core_clk);
    wake_input_n[k] <= 1'b1;
  endtask : press

  task automatic alarm(input logic wk, input int n);
    @(posedge core_clk);
    if (wk)
      weekly_alarm <= 1'b1;
    else
      rtc_alarm <= 1'b1;
    repeat (n) @(posedge core_clk);
    weekly_alarm <= 1'b0;
    rtc_alarm <= 1'b0;
  endtask : alarm

  task automatic set_mpg(input logic v);
    @(posedge core_clk);
    main_power_good <= v;
  endtask : set_mpg
endmodule : bwc_wake_partner
`default_nettype wire

/* File: testbench/test_battery_wake_control_regs.sv */
/*
  self-checking bench for bwc_wake_ctrl against a behavioural image.
  assumes the partner model drives pins and alarms; bench owns the bus.
*/
`timescale 1ns/1ns
`default_nettype none
module test_battery_wake_control_regs;
  logic core_clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [6:0] wake_input_n;
  logic rtc_alarm, weekly_alarm, main_power_good, power_enable_output, irq;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 13;
  int k;
  logic [31:0] d, r;
  // behavioural image of the settings that shape status and output
  logic [6:0] m_pins = 7'h7f, m_pol = 7'h00, m_ien = 7'h7f;
  logic m_ovr = 0, m_lvl = 0, m_byp = 0, m_rlat = 0, m_wlat = 0, m_mpg = 1;
  logic [7:0] t_off [10] = '{8'h04, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28, 8'h10, 8'h08, 8'h30};
  logic [7:0] w_off [6] = '{8'h04, 8'h0c, 8'h14, 8'h20, 8'h28, 8'h10};
  logic [31:0] w_msk [6] = '{32'h0003_007f, 32'h7f, 32'h7f, 32'h7f, 32'h1f, 32'h0};

  bwc_wake_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_input_n(wake_input_n), .rtc_alarm(rtc_alarm), .weekly_alarm(weekly_alarm),
    .main_power_good(main_power_good), .power_enable_output(power_enable_output), .irq(irq));
  bwc_wake_partner i_partner (.core_clk(core_clk), .wake_input_n(wake_input_n),
    .rtc_alarm(rtc_alarm), .weekly_alarm(weekly_alarm), .main_power_good(main_power_good));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] exp_stat();
    logic [6:0] lv;
    logic pw;
    lv = m_pins ^ m_pol;
    pw = (m_ovr && m_mpg) ? m_lvl : ((|(~lv & m_ien)) | m_rlat | m_wlat);
    return {14'h0000, m_rlat, m_wlat, 4'h0, m_byp, m_lvl, m_ovr, pw, 1'b0, lv};
  endfunction : exp_stat

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe; sampled mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : chk_rd

  // clear edge and irq history so later scenarios start clean
  task automatic settle();
    repeat (8) @(posedge core_clk);
    wr(8'h18, 32'h7f);
    wr(8'h1c, 32'h7f);
    rd(8'h24, r);
  endtask : settle

  initial
  begin
    #(100 * 5000);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    m_pins = 7'($random(seed));
    i_partner.set_pins(m_pins);
    // set_pins spends the first edge, so reset spans three edges in all
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk_rd(8'h00, exp_stat());
    foreach (t_off[i])
      chk_rd(t_off[i], (t_off[i] == 8'h0c) ? 32'h7f : 32'h0);
    m_pins = 7'h7f;
    i_partner.set_pins(m_pins);
    settle();
    // random write and read back at offsets 04,0C,14,20,28 and the reserved 0x10
    foreach (w_off[i])
    begin
      d = $random(seed);
      wr(w_off[i], d);
      rd(w_off[i], r);
      chk(r, d & w_msk[i]);
    end
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h7f);
    wr(8'h14, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h08, 32'h0003_007f);
    settle();
    // alarms: latch, interrupt, mask, clear
    wr(8'h28, 32'h04);
    wr(8'h04, 32'h0003_0000);
    i_partner.alarm(1'b0, 1);
    m_rlat = 1;
    repeat (4) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    chk_rd(8'h24, 32'h14);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    chk_rd(8'h00, exp_stat());
    i_partner.alarm(1'b1, 1);
    m_wlat = 1;
    repeat (4) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    chk_rd(8'h00, exp_stat());
    wr(8'h08, 32'h0002_0000);
    m_rlat = 0;
    chk_rd(8'h00, exp_stat());
    wr(8'h08, 32'h0001_0000);
    m_wlat = 0;
    chk_rd(8'h00, exp_stat());
    wr(8'h04, 32'h0);
    i_partner.set_mpg(1'b0);
    m_mpg = 0;
    i_partner.alarm(1'b0, 4);
    repeat (2) @(posedge core_clk);
    chk_rd(8'h00, exp_stat());
    wr(8'h28, 32'h0);
    // firmware override, honoured only with main power good
    wr(8'h00, 32'h0000_0600);
    m_ovr = 1;
    m_lvl = 1;
    repeat (3) @(posedge core_clk);
    chk_rd(8'h00, exp_stat());
    i_partner.set_mpg(1'b1);
    m_mpg = 1;
    repeat (3) @(posedge core_clk);
    chk_rd(8'h00, exp_stat());
    chk({31'h0, power_enable_output}, 32'h1);
    wr(8'h00, 32'h0000_0200);
    m_lvl = 0;
    repeat (2) @(posedge core_clk);
    chk_rd(8'h00, exp_stat());
    wr(8'h00, 32'h0);
    m_ovr = 0;
    settle();
    // filter, edges and polarity on a random pin
    k = {$random(seed)} % 7;
    i_partner.press(k, 2);
    repeat (8) @(posedge core_clk);
    chk_rd(8'h1c, 32'h0);
    i_partner.press(k, 6);
    repeat (8) @(posedge core_clk);
    chk_rd(8'h1c, 32'(1 << k));
    chk_rd(8'h18, 32'(1 << k));
    settle();
    chk_rd(8'h18, 32'h0);
    wr(8'h14, 32'(1 << k));
    m_pol = 7'(1 << k);
    repeat (3) @(posedge core_clk);
    chk_rd(8'h00, exp_stat());
    chk_rd(8'h1c, 32'h0);
    wr(8'h14, 32'h0);
    m_pol = 7'h00;
    wr(8'h00, 32'h0000_0800);
    m_byp = 1;
    i_partner.press(k, 1);
    repeat (4) @(posedge core_clk);
    chk_rd(8'h1c, 32'(1 << k));
    wr(8'h00, 32'hfffc_e800);
    chk_rd(8'h00, exp_stat());
    print_verdict();
  end
endmodule : test_battery_wake_control_regs

bind bwc_wake_ctrl bwc_wake_ctrl_chk #(.N(N)) i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rtc_alarm(rtc_alarm),
  .main_power_good(main_power_good), .power_enable_output(power_enable_output));
`default_nettype wire
